// *** cmt_pkg.sv ***
package cmt_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_COUNT   = 4'h0;
   localparam logic [3:0] ADDR_CAPTURE = 4'h4;
   localparam logic [3:0] ADDR_LIMIT   = 4'h8;
   localparam logic [3:0] ADDR_CONTROL = 4'hc;
   localparam logic [3:0] ADDR_STATUS  = 4'h0;
   localparam logic [4:0] ADDR_CTRL_HI = 5'h10;
   localparam logic [4:0] ADDR_STAT_HI = 5'h14;
   localparam logic [4:0] ADDR_IEN_HI  = 5'h18;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   localparam logic [15:0] LIMIT_RESET = 16'hffff;
   localparam logic [15:0] COUNT_MAX   = 16'hffff;
   localparam logic [2:0] CKS_EXTERNAL = 3'h7;
   // ----------------------------------------------------------------
   // field layouts
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       count_run;       // bit 7
      logic       polarity_invert; // bit 6
      logic       stop_on_limit;   // bit 5
      logic       edge_select;     // bit 4
      logic       mode_select_bit; // bit 3
      logic [2:0] clock_select_field;
   } cmt_ctrl_t;
   typedef struct packed {
      logic       overflow_irq_enable;
      logic       period_limit_irq_enable;
      logic       match_irq_enable;
      logic       pulse_input_enable;
      logic       capture_irq_enable;
      logic [1:0] reserved;
      logic       zero;
   } cmt_ien_t;
   typedef struct packed {
      logic wrap_flag;
      logic period_limit_flag;
      logic match_flag;
      logic capture_flag;
   } cmt_flags_t;
   typedef struct packed {
      logic wrap;
      logic period_limit;
      logic match;
      logic capture;
   } cmt_irq_t;
endpackage : cmt_pkg

// *** cmt_timer.sv ***
`timescale 1ns/1ns
module cmt_timer (
   // clock and reset
   input  wire logic                 CORE_CLK,
   input  wire logic                 RST_N,
   // axi4-lite write address, data and response
   input  wire logic [4:0]           S_AWADDR,
   input  wire logic                 S_AWVALID,
   output logic                      S_AWREADY,
   input  wire logic [31:0]          S_WDATA,
   input  wire logic [3:0]           S_WSTRB,
   input  wire logic                 S_WVALID,
   output logic                      S_WREADY,
   output logic [1:0]                S_BRESP,
   output logic                      S_BVALID,
   input  wire logic                 S_BREADY,
   // axi4-lite read
   input  wire logic [4:0]           S_ARADDR,
   input  wire logic                 S_ARVALID,
   output logic                      S_ARREADY,
   output logic [31:0]               S_RDATA,
   output logic [1:0]                S_RRESP,
   output logic                      S_RVALID,
   input  wire logic                 S_RREADY,
   // outside pins
   input  wire logic                 PULSE_INPUT_PIN,
   input  wire logic                 EXT_COUNT_CLK,
   // interrupt requests
   output cmt_pkg::cmt_irq_t         IRQ
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // control, enable and flag registers
   cmt_pkg::cmt_ctrl_t  ctrl_q, ctrl_d;
   cmt_pkg::cmt_ien_t   ien_q, ien_d;
   cmt_pkg::cmt_flags_t flg_q, flg_d;
   // counter path and pin history
   logic [15:0]         cnt_q, cnt_d;
   logic [15:0]         cap_q, cap_d;
   logic [15:0]         lim_q, lim_d;
   logic [7:0]          pre_q, pre_d;
   logic [1:0]          pin_s_q, ext_s_q;
   logic                pin_p_q, ext_p_q;
   logic                armed_q, armed_d;
   // bus channel state
   logic                aw_q, aw_d;
   logic                w_q, w_d;
   logic                bv_q, bv_d;
   logic                rv_q, rv_d;
   logic [4:0]          awa_q, awa_d;
   logic [31:0]         wd_q, wd_d;
   logic [31:0]         rd_q, rd_d;
   logic [3:0]          ws_q, ws_d;
   logic [1:0]          br_q, br_d;
   logic [1:0]          rr_q, rr_d;

   // one count clock tick for the selected source
   function automatic logic tick_of(input logic [2:0] cks, input logic [7:0] pre,
                                    input logic ext_edge);
      logic t;
      t = 1'b0;
      case (cks)
         3'h0:    t = (pre[0] == 1'b1);
         3'h1:    t = (pre[2:0] == 3'h7);
         3'h2:    t = (pre[3:0] == 4'hf);
         3'h3:    t = (pre[4:0] == 5'h1f);
         3'h4:    t = (pre[5:0] == 6'h3f);
         3'h5:    t = (pre[6:0] == 7'h7f);
         3'h6:    t = (pre == 8'hff);
         default: t = ext_edge;
      endcase
      return t;
   endfunction : tick_of

   // byte-lane merge of an 8-bit field
   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
                                         input logic en);
      return en ? nw : old;
   endfunction : merge8

   // ----------------------------------------------------------------
   // pin synchronisers and edge detect
   // ----------------------------------------------------------------
   // two stages before use; the pulse width limit keeps the external clock visible
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         pin_s_q <= 2'h0;
         ext_s_q <= 2'h0;
         pin_p_q <= 1'b0;
         ext_p_q <= 1'b0;
      end else begin
         pin_s_q <= {pin_s_q[0], PULSE_INPUT_PIN};
         ext_s_q <= {ext_s_q[0], EXT_COUNT_CLK};
         pin_p_q <= pin_s_q[1];
         ext_p_q <= ext_s_q[1];
      end
   end

   // polarity-corrected pin levels, count tick and bus strobes
   logic                pin_lvl, pin_lvl_p, cap_edge, ext_edge;
   logic                tick, wr_go, rd_go;
   assign pin_lvl   = pin_s_q[1] ^ ctrl_q.polarity_invert;
   assign pin_lvl_p = pin_p_q ^ ctrl_q.polarity_invert;
   // rising when edge select is 0 after polarity; falling when 1
   assign cap_edge  = ien_q.pulse_input_enable &&
                      (ctrl_q.edge_select ? (pin_lvl_p && !pin_lvl)
                                          : (!pin_lvl_p && pin_lvl));
   assign ext_edge  = ext_p_q && !ext_s_q[1];
   assign tick      = tick_of(ctrl_q.clock_select_field, pre_q, ext_edge);

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   assign S_AWREADY = !aw_q && !bv_q;
   assign S_WREADY  = !w_q && !bv_q;
   assign S_ARREADY = !rv_q;
   assign S_BVALID  = bv_q;
   assign S_BRESP   = br_q;
   assign S_RVALID  = rv_q;
   assign S_RDATA   = rd_q;
   assign S_RRESP   = rr_q;
   assign wr_go     = aw_q && w_q && !bv_q;
   assign rd_go     = S_ARVALID && !rv_q;

   // write and read channel capture and response
   always_comb begin
      aw_d  = aw_q;
      w_d   = w_q;
      awa_d = awa_q;
      wd_d  = wd_q;
      ws_d  = ws_q;
      bv_d  = bv_q;
      br_d  = br_q;
      rv_d  = rv_q;
      rd_d  = rd_q;
      rr_d  = rr_q;
      if (S_AWVALID && S_AWREADY) begin
         aw_d  = 1'b1;
         awa_d = S_AWADDR;
      end
      if (S_WVALID && S_WREADY) begin
         w_d  = 1'b1;
         wd_d = S_WDATA;
         ws_d = S_WSTRB;
      end
      if (wr_go) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = (awa_q[1:0] == 2'h0 && awa_q <= cmt_pkg::ADDR_IEN_HI)
                ? cmt_pkg::RESP_OKAY : cmt_pkg::RESP_SLVERR;
      end else if (bv_q && S_BREADY) begin
         bv_d = 1'b0;
      end
      if (rd_go) begin
         rv_d = 1'b1;
         rr_d = cmt_pkg::RESP_OKAY;
         case (S_ARADDR)
            {1'b0, cmt_pkg::ADDR_COUNT}:   rd_d = {16'h0000, cnt_q};
            {1'b0, cmt_pkg::ADDR_CAPTURE}: rd_d = {16'h0000, cap_q};
            {1'b0, cmt_pkg::ADDR_LIMIT}:   rd_d = {16'h0000, lim_q};
            {1'b0, cmt_pkg::ADDR_CONTROL}: rd_d = 32'h00000000;
            cmt_pkg::ADDR_CTRL_HI:         rd_d = {24'h000000, ctrl_q};
            cmt_pkg::ADDR_STAT_HI:         rd_d = {28'h0000000, flg_q};
            cmt_pkg::ADDR_IEN_HI:          rd_d = {24'h000000, ien_q[7:1], 1'b0};
            default: begin
               rd_d = 32'h00000000;
               rr_d = cmt_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rv_q && S_RREADY) begin
         rv_d = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         awa_q <= 5'h00;
         wd_q  <= 32'h00000000;
         ws_q  <= 4'h0;
         bv_q  <= 1'b0;
         br_q  <= cmt_pkg::RESP_OKAY;
         rv_q  <= 1'b0;
         rd_q  <= 32'h00000000;
         rr_q  <= cmt_pkg::RESP_OKAY;
      end else begin
         aw_q  <= aw_d;
         w_q   <= w_d;
         awa_q <= awa_d;
         wd_q  <= wd_d;
         ws_q  <= ws_d;
         bv_q  <= bv_d;
         br_q  <= br_d;
         rv_q  <= rv_d;
         rd_q  <= rd_d;
         rr_q  <= rr_d;
      end
   end

   // ----------------------------------------------------------------
   // counter, capture, compare and registers
   // ----------------------------------------------------------------
   // register write strobes; the 8-bit registers take byte lane 0 only
   logic                wr_cnt, wr_lim, wr_ctl, wr_stat, wr_ien;
   logic                run, halted;
   assign wr_cnt  = wr_go && awa_q == {1'b0, cmt_pkg::ADDR_COUNT};
   assign wr_lim  = wr_go && awa_q == {1'b0, cmt_pkg::ADDR_LIMIT};
   assign wr_ctl  = wr_go && awa_q == cmt_pkg::ADDR_CTRL_HI && ws_q[0];
   assign wr_stat = wr_go && awa_q == cmt_pkg::ADDR_STAT_HI && ws_q[0];
   assign wr_ien  = wr_go && awa_q == cmt_pkg::ADDR_IEN_HI && ws_q[0];
   // stop-on-limit halts speed counting while the limit flag stands
   assign halted  = ctrl_q.mode_select_bit && ctrl_q.stop_on_limit && flg_q.period_limit_flag;
   assign run     = (ctrl_q.mode_select_bit || ctrl_q.count_run) && !halted;

   // next counter, capture, limit, control and flag values
   always_comb begin
      cnt_d   = cnt_q;
      cap_d   = cap_q;
      lim_d   = lim_q;
      ctrl_d  = ctrl_q;
      ien_d   = ien_q;
      flg_d   = flg_q;
      armed_d = armed_q;
      pre_d   = run ? pre_q + 8'h01 : 8'h00;
      // software clears flags by writing 0; hardware sets below win
      if (wr_stat) begin
         flg_d = flg_q & cmt_pkg::cmt_flags_t'(wd_q[3:0]);
      end
      if (wr_ctl) begin
         ctrl_d = cmt_pkg::cmt_ctrl_t'(wd_q[7:0]);
         if (!wd_q[3]) begin
            armed_d = 1'b1;
         end
      end
      if (wr_ien) begin
         ien_d      = cmt_pkg::cmt_ien_t'(merge8(ien_q, wd_q[7:0], 1'b1));
         ien_d.zero = 1'b0;
      end
      if (wr_lim) begin
         lim_d = wd_q[15:0];
      end
      if (wr_cnt) begin
         cnt_d = wd_q[15:0];
      end
      if (!ctrl_q.mode_select_bit && !ctrl_q.count_run && !wr_cnt) begin
         // stopped timer mode: counter holds, a software write still lands
         cnt_d = cnt_q;
      end
      if (run && tick) begin
         cnt_d = cnt_q + 16'h0001;
         if (cnt_q == cmt_pkg::COUNT_MAX) begin
            flg_d.wrap_flag = 1'b1;
         end
         // the tick that ends the last equal state sets the match flag,
         // so a counter parked on the limit matches on its first tick
         if (!ctrl_q.mode_select_bit && cnt_q == lim_q) begin
            flg_d.match_flag = 1'b1;
         end
      end
      if (cap_edge && !ctrl_q.mode_select_bit) begin
         cap_d              = cnt_q;
         flg_d.capture_flag = 1'b1;
      end
      if (cap_edge && ctrl_q.mode_select_bit && armed_q) begin
         cnt_d   = 16'h0000;
         armed_d = 1'b0;
      end
   end

   // mode select resets to 0, which is timer mode
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ctrl_q  <= '0;
         ien_q   <= '0;
         flg_q   <= '0;
         cnt_q   <= 16'h0000;
         cap_q   <= 16'h0000;
         lim_q   <= cmt_pkg::LIMIT_RESET;
         pre_q   <= 8'h00;
         armed_q <= 1'b1;
      end else begin
         ctrl_q  <= ctrl_d;
         ien_q   <= ien_d;
         flg_q   <= flg_d;
         cnt_q   <= cnt_d;
         cap_q   <= cap_d;
         lim_q   <= lim_d;
         pre_q   <= pre_d;
         armed_q <= armed_d;
      end
   end

   // ----------------------------------------------------------------
   // interrupt requests
   // ----------------------------------------------------------------
   assign IRQ.wrap         = flg_q.wrap_flag && ien_q.overflow_irq_enable;
   assign IRQ.period_limit = flg_q.period_limit_flag && ien_q.period_limit_irq_enable;
   assign IRQ.match        = flg_q.match_flag && ien_q.match_irq_enable;
   assign IRQ.capture      = flg_q.capture_flag && ien_q.capture_irq_enable;
endmodule : cmt_timer

// *** cmt_monitor.sv ***
`timescale 1ns/1ns
module cmt_monitor (
   // clock and reset
   input wire logic              CORE_CLK,
   input wire logic              RST_N,
   // bus traffic
   input wire logic [4:0]        S_AWADDR,
   input wire logic              S_AWVALID,
   input wire logic              S_AWREADY,
   input wire logic [31:0]       S_WDATA,
   input wire logic              S_WVALID,
   input wire logic              S_WREADY,
   input wire logic              S_BVALID,
   input wire logic              S_BREADY,
   input wire logic [4:0]        S_ARADDR,
   input wire logic              S_ARVALID,
   input wire logic              S_ARREADY,
   input wire logic [31:0]       S_RDATA,
   input wire logic              S_RVALID,
   input wire logic              S_RREADY,
   // requests
   input wire cmt_pkg::cmt_irq_t IRQ
);
   logic [4:0]  aw_q, ar_q;
   logic [7:0]  wd_q, ien_q, ctl_q;
   logic [15:0] cnt_q;
   logic        hold_q;
   // ---------------------------------------------
   // shadow of software writes
   // ---------------------------------------------
   // applied when the write answer is taken, so checks skip the answer cycle
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ien_q <= 8'h00;
         ctl_q <= 8'h00;
         hold_q <= 1'b0;
      end else begin
         if (S_AWVALID && S_AWREADY) aw_q <= S_AWADDR;
         if (S_WVALID && S_WREADY) wd_q <= S_WDATA[7:0];
         if (S_ARVALID && S_ARREADY) ar_q <= S_ARADDR;
         if (S_BVALID && S_BREADY) begin
            hold_q <= 1'b0; // any write may move the counter
            if (aw_q == 5'h18) ien_q <= wd_q;
            if (aw_q == 5'h10) ctl_q <= wd_q;
         end
         if (S_RVALID && S_RREADY && ar_q == 5'h00) begin
            cnt_q <= S_RDATA[15:0];
            hold_q <= !ctl_q[7] && !ctl_q[3];
         end
      end
   end
   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   a_wrap_gated: assert property (!S_BVALID && IRQ.wrap |-> ien_q[7])
      else $error("wrap request while disabled");
   a_limit_gated: assert property (!S_BVALID && IRQ.period_limit |-> ien_q[6])
      else $error("limit request while disabled");
   a_match_gated: assert property (!S_BVALID && IRQ.match |-> ien_q[5])
      else $error("match request while disabled");
   a_capture_gated: assert property (!S_BVALID && IRQ.capture |-> ien_q[3])
      else $error("capture request while disabled");
   a_enable_readback: assert property (S_RVALID && ar_q == 5'h18
      |-> S_RDATA == {24'h0, ien_q[7:1], 1'b0}) else $error("enable readback wrong");
   a_control_readback: assert property (S_RVALID && ar_q == 5'h10
      |-> S_RDATA == {24'h0, ctl_q}) else $error("control readback wrong");
   a_count_holds: assert property (S_RVALID && ar_q == 5'h00 && hold_q
      |-> S_RDATA[15:0] == cnt_q) else $error("stopped counter moved");
   a_read_answer: assert property (S_ARVALID && S_ARREADY |=> S_RVALID ##1 !S_RVALID)
      else $error("read answer late or stuck");
endmodule : cmt_monitor
bind cmt_timer cmt_monitor i_cmt_monitor (.CORE_CLK, .RST_N, .S_AWADDR, .S_AWVALID,
   .S_AWREADY, .S_WDATA, .S_WVALID, .S_WREADY, .S_BVALID, .S_BREADY, .S_ARADDR,
   .S_ARVALID, .S_ARREADY, .S_RDATA, .S_RVALID, .S_RREADY, .IRQ);

// *** cmt_pulse_source.sv ***
`timescale 1ns/1ns
module cmt_pulse_source (
   // tach line and count clock
   output logic pulse_pin,
   output logic count_clk
);
   // count clock stands high outside bursts
   initial begin
      pulse_pin = 1'b0;
      count_clk = 1'b1;
   end
   // new tach level, kept long enough to pass the synchroniser
   task automatic level(input logic v);
      #7;
      pulse_pin = v;
      #200;
   endtask : level
   // falling-edge bursts, each level 50 ns
   task automatic ticks(input int n);
      repeat (n) begin
         #7;
         count_clk = 1'b0;
         #50;
         count_clk = 1'b1;
         #43;
      end
   endtask : ticks
endmodule : cmt_pulse_source

// *** test_cycle_measurement_timer.sv ***
`timescale 1ns/1ns
module test_cycle_measurement_timer;
   logic              CORE_CLK;
   logic              RST_N = 1'b0;
   logic [4:0]        S_AWADDR = 5'h00;
   logic              S_AWVALID = 1'b0;
   logic [31:0]       S_WDATA = 32'h0;
   logic [3:0]        S_WSTRB = 4'h0;
   logic              S_WVALID = 1'b0;
   logic              S_BREADY = 1'b0;
   logic [4:0]        S_ARADDR = 5'h00;
   logic              S_ARVALID = 1'b0;
   logic              S_RREADY = 1'b0;
   logic              S_AWREADY, S_WREADY, S_BVALID, S_ARREADY, S_RVALID;
   logic [1:0]        S_BRESP, S_RRESP, resp;
   logic [31:0]       S_RDATA;
   wire               PULSE_INPUT_PIN, EXT_COUNT_CLK;
   cmt_pkg::cmt_irq_t IRQ;
   int                n_fail = 0;
   int                n_checks = 0;
   int                n_cyc = 0;
   int                divs[7] = '{2, 8, 16, 32, 64, 128, 256};
   cmt_timer i_cmt_timer (.CORE_CLK, .RST_N, .S_AWADDR, .S_AWVALID, .S_AWREADY, .S_WDATA,
      .S_WSTRB, .S_WVALID, .S_WREADY, .S_BRESP, .S_BVALID, .S_BREADY, .S_ARADDR, .S_ARVALID,
      .S_ARREADY, .S_RDATA, .S_RRESP, .S_RVALID, .S_RREADY, .PULSE_INPUT_PIN,
      .EXT_COUNT_CLK, .IRQ);
   cmt_pulse_source i_cmt_pulse_source (.pulse_pin(PULSE_INPUT_PIN),
      .count_clk(EXT_COUNT_CLK));
   initial begin
      CORE_CLK = 1'b0;
      forever #10 CORE_CLK = ~CORE_CLK;
   end
   // ---------------------------------------------
   // bus tasks
   // ---------------------------------------------
   // handshakes sampled at the rising edge; each valid drops once taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic b;
      @(posedge CORE_CLK);
      S_AWADDR <= a;
      S_WDATA <= d;
      S_WSTRB <= 4'hf;
      S_AWVALID <= 1'b1;
      S_WVALID <= 1'b1;
      S_BREADY <= 1'b1;
      do begin
         @(posedge CORE_CLK);
         if (S_AWVALID && S_AWREADY) S_AWVALID <= 1'b0;
         if (S_WVALID && S_WREADY) S_WVALID <= 1'b0;
         b = S_BVALID;
         resp = S_BRESP;
      end while (!b);
      S_BREADY <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      logic r;
      @(posedge CORE_CLK);
      S_ARADDR <= a;
      S_ARVALID <= 1'b1;
      S_RREADY <= 1'b1;
      do begin
         @(posedge CORE_CLK);
         if (S_ARVALID && S_ARREADY) S_ARVALID <= 1'b0;
         r = S_RVALID;
         d = S_RDATA;
         resp = S_RRESP;
      end while (!r);
      S_RREADY <= 1'b0;
   endtask : rd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk(v, exp);
   endtask : rchk
   task automatic irq(input logic [3:0] e);
      @(negedge CORE_CLK);
      chk({28'h0, IRQ}, {28'h0, e});
   endtask : irq
   task automatic summarize();
      if (n_fail == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize
   // hang guard, far above the few thousand cycles needed
   always @(posedge CORE_CLK) begin
      n_cyc++;
      if (n_cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      logic [31:0] v;
      logic        rise;
      repeat (4) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      rchk(5'h18, 32'h0);
      chk({30'h0, resp}, {30'h0, cmt_pkg::RESP_OKAY});
      rchk(5'h10, 32'h0);
      wr(5'h18, 32'hf9);
      rchk(5'h18, 32'hf8);
      wr(5'h18, 32'h0);
      rchk(5'h1c, 32'h0);
      chk({30'h0, resp}, {30'h0, cmt_pkg::RESP_SLVERR});
      wr(5'h1c, 32'h0);
      chk({30'h0, resp}, {30'h0, cmt_pkg::RESP_SLVERR});
      // stopped counter sitting on the limit must not match
      wr(5'h0, 32'h1234);
      wr(5'h8, 32'h1234);
      wr(5'h14, 32'h0);
      repeat (20) @(posedge CORE_CLK);
      rchk(5'h0, 32'h1234);
      rchk(5'h0, 32'h1234);
      rchk(5'h14, 32'h0);
      wr(5'h18, 32'h20);
      wr(5'h10, 32'h80);
      repeat (10) @(posedge CORE_CLK);
      wr(5'h10, 32'h0);
      rchk(5'h14, 32'h2);
      irq(4'h2);
      wr(5'h18, 32'h0);
      irq(4'h0);
      // wrap with its request masked, then unmasked, then cleared
      wr(5'h0, 32'hfff0);
      wr(5'h14, 32'h0);
      wr(5'h10, 32'h80);
      repeat (40) @(posedge CORE_CLK);
      wr(5'h10, 32'h0);
      rchk(5'h14, 32'h8);
      irq(4'h0);
      wr(5'h18, 32'h80);
      irq(4'h8);
      wr(5'h14, 32'h0);
      irq(4'h0);
      wr(5'h18, 32'h0);
      // each divider runs about four ticks
      for (int i = 0; i < 7; i++) begin
         wr(5'h0, 32'h0);
         wr(5'h10, 32'h80 | i);
         repeat (4 * divs[i] - 4) @(posedge CORE_CLK);
         wr(5'h10, 32'h0);
         rd(5'h0, v);
         chk({31'h0, v >= 32'h3 && v <= 32'h5}, 32'h1);
      end
      wr(5'h0, 32'h0);
      wr(5'h10, 32'h87);
      i_cmt_pulse_source.ticks(5);
      wr(5'h10, 32'h0);
      rchk(5'h0, 32'h5);
      // capture: disabled pin first, then every edge setting
      wr(5'h18, 32'h08);
      i_cmt_pulse_source.level(1'b1);
      rchk(5'h14, 32'h0);
      i_cmt_pulse_source.level(1'b0);
      wr(5'h18, 32'h18);
      for (int i = 0; i < 4; i++) begin
         rise = (i[0] == i[1]);
         wr(5'h10, {25'h0, i[1], 1'b0, i[0], 4'h0});
         wr(5'h0, 32'h1230 + i);
         i_cmt_pulse_source.level(rise);
         wr(5'h14, 32'h0);
         i_cmt_pulse_source.level(!rise);
         rchk(5'h14, 32'h0);
         irq(4'h0);
         i_cmt_pulse_source.level(rise);
         rchk(5'h14, 32'h1);
         rchk(5'h4, 32'h1230 + i);
         irq(4'h1);
      end
      // speed mode counts with run clear, first edge restarts
      i_cmt_pulse_source.level(1'b0);
      wr(5'h0, 32'h5000);
      wr(5'h10, 32'h08);
      repeat (20) @(posedge CORE_CLK);
      rd(5'h0, v);
      chk({31'h0, v > 32'h5000 && v < 32'h5100}, 32'h1);
      i_cmt_pulse_source.level(1'b1);
      rd(5'h0, v);
      chk({31'h0, v < 32'h20}, 32'h1);
      wr(5'h10, 32'h0);
      summarize();
   end
endmodule : test_cycle_measurement_timer
